// file: rtl/carry_rotator.sv
/*
 Combinational rotate of a 32-bit value through a carry fill bit.
 Assumes count already limited to 0..31.
*/
`timescale 1ns/10ps
module carry_rotator (
    input wire logic [31:0] value,
    input wire logic [4:0] count,
    input wire logic fill,
    input wire logic to_left,
    output logic [31:0] result
);
    logic [63:0] wide;
    logic [63:0] shifted;
    always_comb begin
        if (to_left) begin
            // Vacated low bits take the carry
            wide = {value, {32{fill}}};
            shifted = wide << count;
            result = shifted[63:32];
        end else begin
            // Vacated high bits take the carry
            wide = {{32{fill}}, value};
            shifted = wide >> count;
            result = shifted[31:0];
        end
    end
endmodule : carry_rotator

// file: rtl/rcsr_pkg.sv
/*
 Constants for the rotate-through-carry and shared-read execution unit.
 Assumes a single 50 MHz clock and a 32-bit core datapath.
*/
// Summary of operation
// - Left rotate through carry fills low bits with old carry, four clocks
// - Left rotate carry takes old bit 31; result written unless suppressed
// - Right rotate through carry fills high bits with old carry, four clocks
// - Right rotate carry update takes old bit 0; zero flag on zero result
// - Count is five-bit immediate or register, chosen by immediate bit
// - Byte read waits for slot, zero-extends byte, zero flag on zero
// - Full read clears two low address bits, stores 32-bit value
// - Halfword read clears low address bit, zero-extends 16-bit value
// - Each shared read takes between 8 and 23 clocks
// - Shared reads always write the destination register
package rcsr_pkg;
    // ------------------------------------------------------------
    // Opcodes and timing
    // ------------------------------------------------------------
    localparam logic [5:0] OP_ROT_LEFT = 6'h0D;
    localparam logic [5:0] OP_ROT_RIGHT = 6'h0C;
    localparam logic [5:0] OP_READ_BYTE = 6'h00;
    localparam logic [5:0] OP_READ_HALF = 6'h01;
    localparam logic [5:0] OP_READ_FULL = 6'h02;
    localparam int ROTATE_CLOCKS = 4;
    localparam int READ_MIN_CLOCKS = 8;
    localparam int READ_MAX_CLOCKS = 23;
    localparam int COUNT_W = 5;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_FULL = 2'h2;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROT = 2'b01,
        ST_WAIT = 2'b10,
        ST_FETCH = 2'b11
    } state_type;
endpackage : rcsr_pkg

// file: rtl/rotate_carry_and_shared_read_unit.sv
/*
 Execution unit for the two rotate-through-carry operations and the three
 shared-memory reads. Assumes the instruction is held steady while start is
 seen, and an arbiter that grants one cycle per rotation of its slots and
 returns read data one cycle after the grant.
*/
`timescale 1ns/10ps
module rotate_carry_and_shared_read_unit #(
    parameter int ADDR_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [5:0] opcode,
    input wire logic zero_flag_update,
    input wire logic carry_flag_update,
    input wire logic no_result_write,
    input wire logic imm_select,
    input wire logic [8:0] src_field,
    input wire logic [31:0] src_value,
    input wire logic [31:0] dst_value,
    input wire logic carry_in,
    output logic busy,
    output logic done,
    output logic result_we,
    output logic [31:0] result,
    output logic zero_we,
    output logic zero_out,
    output logic carry_we,
    output logic carry_out,
    output logic mem_req,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [1:0] mem_size,
    input wire logic mem_grant,
    input wire logic [31:0] mem_rdata
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rcsr_pkg::state_type state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic [5:0] wait_q, wait_d;
    logic [31:0] val_q, val_d;
    logic [4:0] amt_q, amt_d;
    logic fill_q, fill_d, left_q, left_d;
    logic zw_q, zw_d, cw_q, cw_d, nr_q, nr_d, cbit_q, cbit_d;
    logic [1:0] size_q, size_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic done_q, done_d, rwe_q, rwe_d, zwe_q, zwe_d, cwe_q, cwe_d;
    logic zo_q, zo_d, co_q, co_d;
    logic [31:0] res_q, res_d;
    logic [31:0] rot_result;
    logic [31:0] rd_ext;
    logic is_read;

    carry_rotator u_rot (
        .value(val_q),
        .count(amt_q),
        .fill(fill_q),
        .to_left(left_q),
        .result(rot_result)
    );

    // Aligns an address to the access size
    function automatic logic [ADDR_W-1:0] align_addr(
        input logic [ADDR_W-1:0] a,
        input logic [1:0] sz
    );
        logic [ADDR_W-1:0] r;
        r = a;
        if (sz == rcsr_pkg::SIZE_FULL) begin
            r[1:0] = 2'h0;
        end else if (sz == rcsr_pkg::SIZE_HALF) begin
            r[0] = 1'b0;
        end
        return r;
    endfunction : align_addr

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        wait_d = wait_q;
        val_d = val_q;
        amt_d = amt_q;
        fill_d = fill_q;
        left_d = left_q;
        zw_d = zw_q;
        cw_d = cw_q;
        nr_d = nr_q;
        cbit_d = cbit_q;
        size_d = size_q;
        addr_d = addr_q;
        done_d = 1'b0;
        rwe_d = 1'b0;
        zwe_d = 1'b0;
        cwe_d = 1'b0;
        zo_d = zo_q;
        co_d = co_q;
        res_d = res_q;
        is_read = (opcode == rcsr_pkg::OP_READ_BYTE)
            || (opcode == rcsr_pkg::OP_READ_HALF)
            || (opcode == rcsr_pkg::OP_READ_FULL);
        case (size_q)
            rcsr_pkg::SIZE_BYTE: rd_ext = {24'h0, mem_rdata[7:0]};
            rcsr_pkg::SIZE_HALF: rd_ext = {16'h0000, mem_rdata[15:0]};
            default: rd_ext = mem_rdata;
        endcase
        case (state_q)
            rcsr_pkg::ST_IDLE: begin
                if (start) begin
                    zw_d = zero_flag_update;
                    cw_d = carry_flag_update;
                    nr_d = no_result_write;
                    cnt_d = 5'h00;
                    wait_d = 6'h00;
                    if (opcode == rcsr_pkg::OP_ROT_LEFT
                        || opcode == rcsr_pkg::OP_ROT_RIGHT) begin
                        val_d = dst_value;
                        fill_d = carry_in;
                        left_d = (opcode == rcsr_pkg::OP_ROT_LEFT);
                        // Immediate count or low five register bits
                        amt_d = imm_select ? src_field[4:0]
                                           : src_value[4:0];
                        cbit_d = left_d ? dst_value[31]
                                        : dst_value[0];
                        state_d = rcsr_pkg::ST_ROT;
                    end else if (is_read) begin
                        size_d = (opcode == rcsr_pkg::OP_READ_BYTE)
                            ? rcsr_pkg::SIZE_BYTE
                            : (opcode == rcsr_pkg::OP_READ_HALF)
                            ? rcsr_pkg::SIZE_HALF : rcsr_pkg::SIZE_FULL;
                        addr_d = align_addr(imm_select
                            ? ADDR_W'(src_field) : src_value[ADDR_W-1:0],
                            size_d);
                        state_d = rcsr_pkg::ST_WAIT;
                    end
                end
            end
            rcsr_pkg::ST_ROT: begin
                cnt_d = cnt_q + 5'h01;
                // Result issued on the fourth clock
                if (cnt_q == 5'(rcsr_pkg::ROTATE_CLOCKS - 2)) begin
                    res_d = rot_result;
                    rwe_d = !nr_q;
                    zwe_d = zw_q;
                    zo_d = (rot_result == 32'h0000_0000);
                    cwe_d = cw_q;
                    co_d = cbit_q;
                    done_d = 1'b1;
                    state_d = rcsr_pkg::ST_IDLE;
                end
            end
            rcsr_pkg::ST_WAIT: begin
                wait_d = wait_q + 6'h01;
                // Grant only honoured once the minimum latency is reachable
                if (mem_grant && wait_q >= 6'(rcsr_pkg::READ_MIN_CLOCKS - 3))
                    begin
                    state_d = rcsr_pkg::ST_FETCH;
                end
            end
            default: begin
                res_d = rd_ext;
                rwe_d = 1'b1;
                zwe_d = zw_q;
                zo_d = (rd_ext == 32'h0000_0000);
                cwe_d = cw_q;
                co_d = 1'b0;
                done_d = 1'b1;
                state_d = rcsr_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= rcsr_pkg::ST_IDLE;
            cnt_q <= 5'h00;
            wait_q <= 6'h00;
            val_q <= rcsr_pkg::DATA_RESET;
            amt_q <= 5'h00;
            fill_q <= 1'b0;
            left_q <= 1'b0;
            zw_q <= 1'b0;
            cw_q <= 1'b0;
            nr_q <= 1'b0;
            cbit_q <= 1'b0;
            size_q <= rcsr_pkg::SIZE_BYTE;
            addr_q <= '0;
            done_q <= 1'b0;
            rwe_q <= 1'b0;
            zwe_q <= 1'b0;
            cwe_q <= 1'b0;
            zo_q <= 1'b0;
            co_q <= 1'b0;
            res_q <= rcsr_pkg::DATA_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wait_q <= wait_d;
            val_q <= val_d;
            amt_q <= amt_d;
            fill_q <= fill_d;
            left_q <= left_d;
            zw_q <= zw_d;
            cw_q <= cw_d;
            nr_q <= nr_d;
            cbit_q <= cbit_d;
            size_q <= size_d;
            addr_q <= addr_d;
            done_q <= done_d;
            rwe_q <= rwe_d;
            zwe_q <= zwe_d;
            cwe_q <= cwe_d;
            zo_q <= zo_d;
            co_q <= co_d;
            res_q <= res_d;
        end
    end

    assign busy = (state_q != rcsr_pkg::ST_IDLE);
    assign done = done_q;
    assign result_we = rwe_q;
    assign result = res_q;
    assign zero_we = zwe_q;
    assign zero_out = zo_q;
    assign carry_we = cwe_q;
    assign carry_out = co_q;
    assign mem_req = (state_q == rcsr_pkg::ST_WAIT);
    assign mem_addr = addr_q;
    assign mem_size = size_q;
endmodule : rotate_carry_and_shared_read_unit

// file: sim/rcsr_chk.sv
/*
 Checker for the rotate and shared-read unit.
 Assumes it is bound to the unit's top module.
*/
`timescale 1ns/10ps
module rcsr_chk #(
    parameter int ADDR_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [5:0] opcode,
    input wire logic no_result_write,
    input wire logic busy,
    input wire logic done,
    input wire logic result_we,
    input wire logic [31:0] result,
    input wire logic zero_we,
    input wire logic zero_out,
    input wire logic carry_we,
    input wire logic carry_out,
    input wire logic mem_req,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [1:0] mem_size
);
    logic take;
    logic rd_start;
    logic in_read_q;
    logic in_read_d;
    assign take = start && !busy && clk_en;
    assign rd_start = take && opcode inside {rcsr_pkg::OP_READ_BYTE,
        rcsr_pkg::OP_READ_HALF, rcsr_pkg::OP_READ_FULL};
    always_comb begin
        in_read_d = in_read_q;
        if (rd_start) begin
            in_read_d = 1'b1;
        end else if (done) begin
            in_read_d = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            in_read_q <= 1'b0;
        end else begin
            in_read_q <= in_read_d;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence rot_take;
        take && (opcode == rcsr_pkg::OP_ROT_LEFT
            || opcode == rcsr_pkg::OP_ROT_RIGHT);
    endsequence
    sequence rot_run;
        ##1 (busy && !done)[*3] ##1 done;
    endsequence
    a_rot_four_clocks: assert property (
        rot_take |-> rot_run ##0 (result_we == !$past(no_result_write, 4)))
        else $error("rotate timing or write wrong");
    a_read_window: assert property (
        rd_start |=> !done[*7] ##[1:16] done)
        else $error("read outside its window");
    a_req_stable: assert property (
        mem_req && $past(mem_req) |-> $stable(mem_addr) && $stable(mem_size))
        else $error("address moved during request");
    a_full_align: assert property (
        mem_req && mem_size == rcsr_pkg::SIZE_FULL |-> mem_addr[1:0] == 2'h0)
        else $error("full read not aligned");
    a_half_align: assert property (
        mem_req && mem_size == rcsr_pkg::SIZE_HALF |-> mem_addr[0] == 1'h0)
        else $error("halfword read not aligned");
    a_read_writes: assert property (
        done && in_read_q |-> result_we)
        else $error("read did not write");
    a_read_carry: assert property (
        done && in_read_q && carry_we |-> !carry_out)
        else $error("read carry not cleared");
    a_byte_zext: assert property (
        done && in_read_q && mem_size == rcsr_pkg::SIZE_BYTE
        |-> result[31:8] == 24'h0)
        else $error("byte not zero extended");
    a_zero_flag: assert property (
        done && zero_we |-> zero_out == (result == 32'h0))
        else $error("zero flag wrong");
endmodule : rcsr_chk

// file: sim/rotate_carry_and_shared_read_unit_tb.sv
/*
 Bench for the rotate and shared-read unit.
 Assumes the slot arbiter model and the checker.
*/
`timescale 1ns/10ps
module rotate_carry_and_shared_read_unit_tb;
    logic mclk, resetn, clk_en, start, zw, cw, nr, imm, c_in;
    logic [5:0] opcode;
    logic [8:0] src_field;
    logic [31:0] sv, dv, rdata, result;
    logic busy, done, result_we, zero_we, zero_out, carry_we, carry_out;
    logic mem_req, grant;
    logic [15:0] addr;
    logic [1:0] mem_size;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int ticks = 0;
    rotate_carry_and_shared_read_unit #(.ADDR_W(16)) uut (.mclk(mclk),
        .resetn(resetn), .clk_en(clk_en), .start(start), .opcode(opcode),
        .zero_flag_update(zw), .carry_flag_update(cw), .no_result_write(nr),
        .imm_select(imm), .src_field(src_field), .src_value(sv),
        .dst_value(dv), .carry_in(c_in), .busy(busy), .done(done),
        .result_we(result_we), .result(result), .zero_we(zero_we),
        .zero_out(zero_out), .carry_we(carry_we), .carry_out(carry_out),
        .mem_req(mem_req), .mem_addr(addr), .mem_size(mem_size),
        .mem_grant(grant), .mem_rdata(rdata));
    slot_arbiter arb (.mclk(mclk), .resetn(resetn), .mem_req(mem_req),
        .mem_addr(addr), .mem_grant(grant), .mem_rdata(rdata));
    task automatic close_out();
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic issue(input logic [5:0] op, input logic [3:0] fx,
        input logic [8:0] sf, input logic [31:0] s, d, input logic c);
        @(posedge mclk);
        #1;
        {opcode, zw, cw, nr, imm, src_field} = {op, fx, sf};
        {sv, dv, c_in} = {s, d, c};
        start = 1'b1;
        @(posedge mclk);
        #1;
        start = 1'b0;
        cycles = 1;
        while (done !== 1'b1 && cycles < 40) begin
            @(posedge mclk);
            #1;
            cycles++;
        end
    endtask : issue
    task automatic rot_one(input logic l, input logic [3:0] fx,
        input logic [8:0] sf, input logic [31:0] s, d, input logic c,
        input logic [31:0] r, input logic z, co);
        issue(l ? rcsr_pkg::OP_ROT_LEFT : rcsr_pkg::OP_ROT_RIGHT, fx, sf, s,
            d, c);
        check("rot clocks", cycles, 4);
        check("rot busy", busy, 1'b0);
        check("rot flag we", {zero_we, carry_we}, fx[3:2]);
        check("rot result", result, r);
        check("rot zero", zero_out, z);
        check("rot carry", carry_out, co);
        check("rot write", result_we, !fx[1]);
    endtask : rot_one
    task automatic read_one(input logic [5:0] op, input logic [3:0] fx,
        input logic [8:0] sf, input logic [31:0] s, input logic [15:0] a,
        input logic [31:0] mask);
        issue(op, fx, sf, s, 32'hDEAD_BEEF, 1'b1);
        check("read addr", addr, a);
        check("read data", result, {~a, a} & mask);
        check("read zero", zero_out, ({~a, a} & mask) == 32'h0);
        check("read zero we", zero_we, fx[3]);
        check("read carry", {carry_we, carry_out}, 2'h2);
        check("read write", result_we, 1'b1);
        check("read time", cycles <= rcsr_pkg::READ_MAX_CLOCKS, 1'b1);
        check("read min", cycles >= rcsr_pkg::READ_MIN_CLOCKS, 1'b1);
    endtask : read_one
    task automatic test_rotate_left();
        rot_one(1'h1, 4'hD, 9'h0, 32'h0, 32'h8000_0000, 1'h1,
            32'h8000_0000, 1'h0, 1'h1);
        rot_one(1'h1, 4'hD, 9'h1, 32'h0, 32'h8000_0000, 1'h0,
            32'h0, 1'h1, 1'h1);
        rot_one(1'h1, 4'hD, 9'h2, 32'h0, 32'h2108_4048, 1'h1,
            32'h8421_0123, 1'h0, 1'h0);
        rot_one(1'h1, 4'hC, 9'h0, 32'hFFFF_FFE4, 32'h8765_4321, 1'h1,
            32'h7654_321F, 1'h0, 1'h1);
        rot_one(1'h1, 4'hF, 9'h4, 32'h0, 32'h8765_4321, 1'h0,
            32'h7654_3210, 1'h0, 1'h1);
    endtask : test_rotate_left
    task automatic test_rotate_right();
        rot_one(1'h0, 4'hD, 9'h1, 32'h0, 32'h1, 1'h0,
            32'h0, 1'h1, 1'h1);
        rot_one(1'h0, 4'hD, 9'h1, 32'h0, 32'h1, 1'h1,
            32'h8000_0000, 1'h0, 1'h1);
        rot_one(1'h0, 4'hD, 9'h2, 32'h0, 32'h18C2_1084, 1'h1,
            32'hC630_8421, 1'h0, 1'h0);
        rot_one(1'h0, 4'hD, 9'h4, 32'h0, 32'h8765_4321, 1'h1,
            32'hF876_5432, 1'h0, 1'h1);
        rot_one(1'h0, 4'hC, 9'h0, 32'hFFFF_FFE4, 32'h8765_4321, 1'h0,
            32'h0876_5432, 1'h0, 1'h1);
    endtask : test_rotate_right
    task automatic test_freeze();
        @(posedge mclk);
        #1;
        clk_en = 1'b0;
        opcode = rcsr_pkg::OP_ROT_LEFT;
        start = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("frozen start", {busy, done, mem_req}, 3'h0);
        start = 1'b0;
        clk_en = 1'b1;
    endtask : test_freeze
    task automatic test_reads();
        read_one(rcsr_pkg::OP_READ_BYTE, 4'hD, 9'h0, 32'h0, 16'h0,
            32'hFF);
        read_one(rcsr_pkg::OP_READ_BYTE, 4'hD, 9'h1FF, 32'h0, 16'h1FF,
            32'hFF);
        read_one(rcsr_pkg::OP_READ_HALF, 4'hD, 9'hF3, 32'h0, 16'hF2,
            32'hFFFF);
        read_one(rcsr_pkg::OP_READ_HALF, 4'hC, 9'h0, 32'h1235, 16'h1234,
            32'hFFFF);
        read_one(rcsr_pkg::OP_READ_FULL, 4'hD, 9'hF3, 32'h0, 16'hF0,
            32'hFFFF_FFFF);
        read_one(rcsr_pkg::OP_READ_FULL, 4'hF, 9'h7, 32'h0, 16'h4,
            32'hFFFF_FFFF);
    endtask : test_reads
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 3000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        {resetn, start, opcode, zw, cw, nr, imm, src_field, sv, dv, c_in} = '0;
        clk_en = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        resetn = 1'b1;
        test_rotate_left();
        test_freeze();
        test_rotate_right();
        test_reads();
        close_out();
    end
endmodule : rotate_carry_and_shared_read_unit_tb
bind rotate_carry_and_shared_read_unit rcsr_chk #(.ADDR_W(ADDR_W)) chk (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .start(start),
    .opcode(opcode), .no_result_write(no_result_write), .busy(busy),
    .done(done), .result_we(result_we), .result(result), .zero_we(zero_we),
    .zero_out(zero_out), .carry_we(carry_we), .carry_out(carry_out),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size));

// file: sim/slot_arbiter.sv
/*
 Round-robin shared memory model: one slot in sixteen is ours.
 Assumes a 16-bit address; data is a pattern of the address.
*/
`timescale 1ns/10ps
module slot_arbiter (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_grant,
    output logic [31:0] mem_rdata
);
    logic [3:0] slot_q;
    assign mem_grant = mem_req && slot_q == 4'h0;
    // Data valid one cycle after grant, otherwise it toggles
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            slot_q <= 4'h0;
            mem_rdata <= 32'h0;
        end else begin
            slot_q <= slot_q + 4'h1;
            mem_rdata <= mem_grant ? {~mem_addr, mem_addr} : ~mem_rdata;
        end
    end
endmodule : slot_arbiter
